/* File: src/period_timer_pkg.sv */
// Package for the 8-bit period timer: register map, field layout, reset values.
// Assumes an APB slave with 32-bit data; offsets are register indices, byte address = 4 * index.
package period_timer_pkg;

  // ==========================================================
  // Register indices and byte addresses
  // ==========================================================
  localparam logic [7:0] IDX_PERIPH_FLAG   = 8'h0c;
  localparam logic [7:0] IDX_COUNT         = 8'h11;
  localparam logic [7:0] IDX_CONTROL       = 8'h12;
  localparam logic [7:0] IDX_PERIPH_ENABLE = 8'h8c;
  localparam logic [7:0] IDX_PERIOD        = 8'h92;
  localparam logic [9:0] ADDR_PERIPH_FLAG   = {IDX_PERIPH_FLAG, 2'b00};
  localparam logic [9:0] ADDR_COUNT         = {IDX_COUNT, 2'b00};
  localparam logic [9:0] ADDR_CONTROL       = {IDX_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_PERIPH_ENABLE = {IDX_PERIPH_ENABLE, 2'b00};
  localparam logic [9:0] ADDR_PERIOD        = {IDX_PERIOD, 2'b00};
  localparam int         ADDR_W             = 10;

  // ==========================================================
  // Field positions and reset values
  // ==========================================================
  localparam int         MATCH_IRQ_BIT   = 1;
  localparam logic [7:0] COUNT_RESET     = 8'h00;
  localparam logic [7:0] PERIOD_RESET    = 8'hff;
  localparam logic [7:0] CONTROL_MASK    = 8'h7f;
  localparam logic [7:0] FLAG_MASK       = 8'h02;
  localparam logic [3:0] PRE_DIV4_LAST   = 4'h3;
  localparam logic [3:0] PRE_DIV16_LAST  = 4'hf;

  // Control register layout, bit 7 unimplemented
  typedef struct packed {
    logic       unused;
    logic [3:0] post_divide_select;
    logic       run_enable;
    logic [1:0] pre_divide_select;
  } control_reg_t;

  localparam control_reg_t CONTROL_RESET = '0;

endpackage

/* File: src/match_postscaler.sv */
// Postscaler: counts period matches, pulses once every select+1 matches.
// Assumes match_pulse is a one-cycle pulse on pclk; clear has priority.
`timescale 1ns/1ps
`default_nettype none
module match_postscaler (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       match_pulse,
  input  wire logic [3:0] ratio_select,
  output logic            out_pulse
);
  logic [3:0] match_count;

  // ==========================================================
  // Match counter
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_count <= 4'h0;
    end else if (clear) begin
      match_count <= 4'h0;                              // [RULE9]
    end else if (match_pulse) begin
      if (match_count >= ratio_select) begin
        match_count <= 4'h0;                            // [RULE5] [RULE6]
      end else begin
        match_count <= match_count + 4'h1;
      end
    end
  end

  assign out_pulse = match_pulse && !clear && (match_count >= ratio_select); // [RULE5]
endmodule
`default_nettype wire

/* File: src/period_timer.sv */
// Top of the 8-bit period timer with APB register access and level interrupt.
// Assumes pclk is the instruction clock (oscillator / 4) and an APB master on pclk.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: Counter counts up from zero; after matching period it loads zero next tick.
// RULE2: Period register is read/write and resets to all ones.
// RULE3: Counter clock is the instruction clock, passed through the prescaler.
// RULE4: Prescale select bits 1:0: 00 divide 1, 01 divide 4, 1x divide 16.
// RULE5: Matches feed a 4-bit postscaler giving one output per N matches.
// RULE6: Postscale select bits 6:3 set N to value plus one.
// RULE7: Each postscaler output sets match interrupt flag, bit 1 of flag register.
// RULE8: Run enable at bit 2 lets the timer count; zero stops it.
// RULE9: Prescaler and postscaler clear on count write, control write and reset.
// RULE10: Control write leaves the count value unchanged.
// RULE11: Count register is read/write and resets to zero.
// RULE12: Control bit 7 ignores writes and reads zero.
// RULE13: Period match event is an output for the PWM time base.
// RULE14: Flag stays set until cleared by software; enable gates the request.
// RULE15: With run off, count and scalers hold; count access still works.
module period_timer
  import period_timer_pkg::*;
(
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [period_timer_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  output logic                                period_match,
  output logic                                irq
);
  import period_timer_pkg::*;

  // ==========================================================
  // Register state
  // ==========================================================
  logic [7:0]   count_value;
  logic [7:0]   period_value;
  control_reg_t control_reg;
  logic [7:0]   periph_flag_reg;
  logic [7:0]   periph_enable_reg;
  logic [3:0]   pre_count;
  logic         access;
  logic         wr;
  logic         wr_count;
  logic         wr_control;
  logic         wr_flag;
  logic         scaler_clear;
  logic         tick;
  logic         match_now;
  logic         post_pulse;
  logic         mapped;
  logic [3:0]   pre_last;
  logic [31:0]  next_rdata;

  // ==========================================================
  // APB decode; zero-wait access phase
  // ==========================================================
  assign access     = psel && penable;
  assign wr         = access && pwrite;
  assign wr_count   = wr && (paddr == ADDR_COUNT);
  assign wr_control = wr && (paddr == ADDR_CONTROL);
  assign wr_flag    = wr && (paddr == ADDR_PERIPH_FLAG);
  assign scaler_clear = wr_count || wr_control;                 // [RULE9]

  always_comb begin
    mapped     = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_PERIPH_FLAG:   next_rdata = {24'h00_0000, periph_flag_reg};
      ADDR_COUNT:         next_rdata = {24'h00_0000, count_value};
      ADDR_CONTROL:       next_rdata = {24'h00_0000, control_reg & CONTROL_MASK}; // [RULE12]
      ADDR_PERIPH_ENABLE: next_rdata = {24'h00_0000, periph_enable_reg};
      ADDR_PERIOD:        next_rdata = {24'h00_0000, period_value};
      default:            mapped     = 1'b0;
    endcase
  end

  // Answer registered in setup, so pready is high in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= mapped ? next_rdata : 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Control, period and enable registers
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= CONTROL_RESET;
    end else if (wr_control) begin
      control_reg <= control_reg_t'(pwdata[7:0] & CONTROL_MASK); // [RULE12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_value <= PERIOD_RESET;                             // [RULE2]
    end else if (wr && paddr == ADDR_PERIOD) begin
      period_value <= pwdata[7:0];                              // [RULE2]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_enable_reg <= 8'h00;
    end else if (wr && paddr == ADDR_PERIPH_ENABLE) begin
      periph_enable_reg <= pwdata[7:0] & FLAG_MASK;
    end
  end

  // ==========================================================
  // Prescaler on the instruction clock
  // ==========================================================
  always_comb begin
    unique case (control_reg.pre_divide_select)                 // [RULE4]
      2'b00:   pre_last = 4'h0;
      2'b01:   pre_last = PRE_DIV4_LAST;
      default: pre_last = PRE_DIV16_LAST;
    endcase
  end

  assign tick = control_reg.run_enable && !scaler_clear && (pre_count >= pre_last); // [RULE3] [RULE8]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_count <= 4'h0;                                        // [RULE9]
    end else if (scaler_clear) begin
      pre_count <= 4'h0;                                        // [RULE9]
    end else if (control_reg.run_enable) begin                  // [RULE15]
      pre_count <= (pre_count >= pre_last) ? 4'h0 : pre_count + 4'h1; // [RULE3]
    end
  end

  // ==========================================================
  // Count register and period compare
  // ==========================================================
  assign match_now = tick && (count_value == period_value);     // [RULE1]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= COUNT_RESET;                               // [RULE11]
    end else if (wr_count) begin
      count_value <= pwdata[7:0];                               // [RULE11] [RULE15]
    end else if (tick) begin                                    // [RULE10]
      count_value <= match_now ? 8'h00 : count_value + 8'h01;   // [RULE1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_match <= 1'b0;
    end else begin
      period_match <= match_now;                                // [RULE13]
    end
  end

  // ==========================================================
  // Postscaler
  // ==========================================================
  match_postscaler u_post (
    .pclk         (pclk),
    .presetn      (presetn),
    .clear        (scaler_clear),
    .match_pulse  (match_now),
    .ratio_select (control_reg.post_divide_select),
    .out_pulse    (post_pulse)
  );

  // ==========================================================
  // Interrupt flag and request
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_flag_reg <= 8'h00;
    end else begin
      if (wr_flag) begin
        // Write one clears; set below wins
        periph_flag_reg <= periph_flag_reg & ~(pwdata[7:0] & FLAG_MASK); // [RULE14]
      end
      if (post_pulse) begin
        periph_flag_reg[MATCH_IRQ_BIT] <= 1'b1;                 // [RULE7]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(periph_flag_reg & periph_enable_reg);            // [RULE14]
    end
  end

endmodule
`default_nettype wire

/* File: tb/period_timer_checker.sv */
// Checker: bus handshake and timer relations at the timer's ports.
// Assumes it is bound to period_timer; one clock, async low reset.
`timescale 1ns/1ps
`default_nettype none
module period_timer_checker
  import period_timer_pkg::*;
(
  input wire logic                                 pclk,
  input wire logic                                 presetn,
  input wire logic                                 psel,
  input wire logic                                 penable,
  input wire logic                                 pwrite,
  input wire logic [period_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                          pwdata,
  input wire logic [31:0]                          prdata,
  input wire logic                                 pready,
  input wire logic                                 pslverr,
  input wire logic                                 period_match,
  input wire logic                                 irq
);
  logic mapped;
  logic wr_done;
  logic run_q;
  assign mapped = paddr inside {ADDR_PERIPH_FLAG, ADDR_COUNT, ADDR_CONTROL, ADDR_PERIPH_ENABLE, ADDR_PERIOD};
  assign wr_done = psel && pready && pwrite;
  // Tracks the run bit last written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_q <= 1'b0;
    else if (wr_done && paddr == ADDR_CONTROL) run_q <= pwdata[2];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_on_unmapped: assert property (psel && !penable && !mapped |=> pslverr && pready) else $error("no err");
  a_err_only_unmapped: assert property (pslverr |-> pready && !mapped) else $error("false err");
  a_ctrl_top_zero: assert property (pready && !pwrite && paddr == ADDR_CONTROL |-> prdata[31:7] == '0)
    else $error("control bit 7 set");
  a_flag_only_bit: assert property (pready && !pwrite && paddr == ADDR_PERIPH_FLAG |-> (prdata & ~32'(FLAG_MASK)) == '0)
    else $error("stray flag bit");
  a_upper_read_zero: assert property (pready && !pwrite |-> prdata[31:8] == '0) else $error("upper bits set");
  a_run_off_quiet: assert property ((!run_q)[*3] |-> !period_match) else $error("match while off");
  a_irq_has_cause: assert property ($rose(irq) |-> $past(period_match) || $past(period_match, 2) ||
    $past(period_match, 3) || $past(wr_done, 2)) else $error("irq without cause");
  cover property (period_match);
  cover property ($rose(irq));
  cover property (pslverr);
endmodule
`default_nettype wire

/* File: tb/period_timer_bench.sv */
// Bench: drives the timer over APB and judges counts, scalers and flags.
// Assumes period_timer and its checker; 40 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
module period_timer_bench;
  import period_timer_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic [31:0]       q;
  logic              pready, pslverr, period_match, irq, err;
  int                n_mismatch = 0;
  int                num_checks = 0;
  int                cyc = 0;
  always #12.5 pclk = ~pclk;
  period_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .period_match(period_match), .irq(irq));
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // Cycles between two successive matches
  task automatic gap(output int n);
    while (period_match !== 1'b1) @(posedge pclk);
    n = 1;
    @(posedge pclk);
    while (period_match !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic t_reset;
    rdc(ADDR_COUNT, 32'h0);
    rdc(ADDR_PERIOD, 32'hff);
    rdc(ADDR_CONTROL, 32'h0);
    rdc(ADDR_PERIPH_FLAG, 32'h0);
    rdc(ADDR_PERIPH_ENABLE, 32'h0);
    bus(1'b0, 10'h3fc, 32'h0);
    chk({31'h0, err}, 32'h1);
    bus(1'b1, ADDR_PERIOD, 32'h5a);
    rdc(ADDR_PERIOD, 32'h5a);
    $display("Test reset done");
  endtask
  task automatic t_prescale;
    int n;
    int dv[4] = '{1, 4, 16, 16};
    bus(1'b1, ADDR_PERIOD, 32'h2);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, ADDR_CONTROL, 32'h4 | s);
      gap(n);
      gap(n);
      chk(n, 3 * dv[s]);
    end
    $display("Test prescale done");
  endtask
  task automatic t_post;
    int m;
    int sel[3] = '{0, 1, 15};
    bus(1'b1, ADDR_PERIPH_ENABLE, 32'h2);
    foreach (sel[i]) begin
      bus(1'b1, ADDR_CONTROL, 32'h0);
      bus(1'b1, ADDR_PERIPH_FLAG, 32'h2);
      bus(1'b1, ADDR_COUNT, 32'h0);
      bus(1'b1, ADDR_CONTROL, 32'h4 | (sel[i] << 3));
      m = 0;
      while (irq !== 1'b1) begin
        @(posedge pclk);
        if (period_match === 1'b1) m++;
      end
      chk(m, sel[i] + 1);
    end
    bus(1'b1, ADDR_CONTROL, 32'h0);
    bus(1'b1, ADDR_PERIPH_ENABLE, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rdc(ADDR_PERIPH_FLAG, 32'h2);
    bus(1'b1, ADDR_PERIPH_FLAG, 32'h2);
    rdc(ADDR_PERIPH_FLAG, 32'h0);
    $display("Test postscale done");
  endtask
  task automatic t_run;
    bus(1'b1, ADDR_CONTROL, 32'hff);
    rdc(ADDR_CONTROL, 32'h7f);
    bus(1'b1, ADDR_PERIOD, 32'hff);
    bus(1'b1, ADDR_CONTROL, 32'h7);
    bus(1'b1, ADDR_COUNT, 32'h40);
    bus(1'b1, ADDR_CONTROL, 32'h7);
    rdc(ADDR_COUNT, 32'h40);
    bus(1'b1, ADDR_CONTROL, 32'h3);
    repeat (40) @(posedge pclk);
    rdc(ADDR_COUNT, 32'h40);
    bus(1'b1, ADDR_COUNT, 32'h12);
    rdc(ADDR_COUNT, 32'h12);
    $display("Test run control done");
  endtask
  // Reset in mid-run while the timer counts
  task automatic t_rereset;
    bus(1'b1, ADDR_PERIOD, 32'h5a);
    bus(1'b1, ADDR_COUNT, 32'h33);
    bus(1'b1, ADDR_CONTROL, 32'h4);
    repeat (5) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_COUNT, 32'h0);
    rdc(ADDR_PERIOD, 32'hff);
    rdc(ADDR_CONTROL, 32'h0);
    $display("Test second reset done");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_prescale();
    t_post();
    t_run();
    t_rereset();
    end_of_test();
  end
endmodule
bind period_timer period_timer_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .period_match(period_match), .irq(irq));
`default_nettype wire
